//--- hdl/trace_output_port.sv
// Trace output port: bank multiplexer, capture pipeline and register slave
//
// Behaviour
// R1: Synchronous mode registers trace data on the capture clock before pins.
// R2: Asynchronous mode drives pins from the selected bank combinationally.
// R3: Asynchronous mode turns the trace clock pin into one more data bit.
// R4: Always-on build keeps trace logic and drivers enabled permanently.
// R5: Always-on build selects bank 0 right after configuration.
// R6: Always-on defaults off; allowed only with asynchronous capture.
// R7: Frequency range tunes synchronous pipeline only; ignored when asynchronous.
// R8: Auto-setup, default on, lets the analyzer map pods and tune sampling.
// R9: Run-time selectable multiplexer over 1 to 64 signal banks; the build check accepts only powers of two.
// R10: Double-rate output permitted only in synchronous mode.
// R11: Bank width is pins times rate, plus one pin when asynchronous.
// R12: Trace data pin count is 4 to 128.
// R13: Without always-on, outputs stay disabled until software enables them.
`timescale 1ns/1ps
`include "trace_port_consts.svh"

module trace_output_port
    import trace_port_pkg::*;
#(
    parameter int             PIN_COUNT   = 8,
    parameter int             BANK_COUNT  = 4,
    parameter bit             SYNC_MODE   = 1'b1,
    parameter int             TDM_RATE    = 1,
    parameter bit             ALWAYS_ON   = 1'b0,
    parameter bit             AUTO_SETUP  = 1'b1,
    parameter freq_range_type FREQ_RANGE  = FREQ_301_500,
    parameter int             PIPE_STAGES = 2,
    localparam int            WIDE_PINS   = SYNC_MODE ? PIN_COUNT
                                                      : PIN_COUNT + 1,
    localparam int            BANK_WIDTH  = WIDE_PINS * TDM_RATE
) (
    // Register bus clock and reset
    input  wire logic                                  aclk,
    input  wire logic                                  aresetn,
    // AXI4-Lite slave
    input  wire axil_req_type                          axil_req,
    output      axil_rsp_type                          axil_rsp,
    // Capture clock and its reset
    input  wire logic                                  capture_clk,
    input  wire logic                                  capture_resetn,
    // Signal banks
    input  wire logic [BANK_COUNT-1:0][BANK_WIDTH-1:0] bank_data,
    // Pins toward the probe connector
    output      logic                                  trace_clock_pin,
    output      logic                                  trace_clock_pin_oe,
    output      logic [PIN_COUNT-1:0]                  trace_data_pins,
    output      logic                                  trace_data_pins_oe
);

    ////////////////////////////////////////////////////////////////////////
    // Build-time checks

    localparam int SEL_W = 6;

    // A bad combination reports an error when simulation starts; the port is still built
    initial begin
        if (PIN_COUNT < 4 || PIN_COUNT > 128) begin // R12
            $error("pin count out of range");
        end
        if (!(BANK_COUNT inside {1, 2, 4, 8, 16, 32, 64})) begin // R9
            $error("bank count not supported");
        end
        if (ALWAYS_ON && SYNC_MODE) begin // R6
            $error("always-on needs asynchronous capture");
        end
        if (TDM_RATE == 2 && !SYNC_MODE) begin // R10
            $error("double rate needs synchronous capture");
        end
        if (TDM_RATE != 1 && TDM_RATE != 2) begin // R10
            $error("rate must be 1 or 2");
        end
        if (BANK_COUNT > (1 << SEL_W)) begin // R9
            $error("bank count exceeds the select field");
        end
        if (PIPE_STAGES < 1) begin // R7
            $error("pipeline needs at least one stage");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus-domain state

    // One write and one read in flight; each ready is just the inverse
    // of its holding flag, so no read is taken while a read answer waits,
    // but a new write address and data can be taken while bvalid waits
    typedef struct packed {
        // Write channel
        logic        aw_held;
        logic [11:0] aw_addr;
        logic        w_held;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        // Read channel
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        // Control register
        logic        enable;
        logic [5:0]  bank;
    } bus_state_type;

    bus_state_type bus_r;
    bus_state_type bus_nxt;

    // Always-on forces enable and bank 0 regardless of software
    logic          eff_enable;
    logic [5:0]    eff_bank;
    logic [31:0]   cfg_word;
    logic [31:0]   stat_word;
    logic [31:0]   ctrl_word;
    logic          wr_go;
    logic          rd_go;
    logic          wr_ctrl;
    logic          wr_known;

    always_comb begin
        eff_enable = ALWAYS_ON ? 1'b1 : bus_r.enable;    // R4 R13
        eff_bank   = ALWAYS_ON ? `BANK_RESET : bus_r.bank; // R5
    end

    always_comb begin
        cfg_word = 32'h0000_0000;
        cfg_word[`CFG_SYNC_BIT]   = SYNC_MODE;
        cfg_word[`CFG_ALWAYS_BIT] = ALWAYS_ON;
        cfg_word[`CFG_AUTO_BIT]   = AUTO_SETUP;            // R8
        cfg_word[`CFG_TDM2_BIT]   = (TDM_RATE == 2);
        cfg_word[`CFG_FREQ_MSB:`CFG_FREQ_LSB] = 2'(FREQ_RANGE);
        cfg_word[`CFG_PINS_MSB:`CFG_PINS_LSB] = 8'(PIN_COUNT);
        cfg_word[`CFG_BANKS_MSB:`CFG_BANKS_LSB] = 7'(BANK_COUNT);
        stat_word = 32'h0000_0000;
        stat_word[`STAT_ENABLE_BIT] = eff_enable;
        stat_word[`STAT_BANK_MSB:`STAT_BANK_LSB] = eff_bank;
        ctrl_word = 32'h0000_0000;
        ctrl_word[`CTRL_ENABLE_BIT] = bus_r.enable;
        ctrl_word[`CTRL_BANK_MSB:`CTRL_BANK_LSB] = bus_r.bank;
    end

    assign wr_go = bus_r.aw_held && bus_r.w_held && !bus_r.bvalid;
    assign rd_go = axil_req.arvalid && !bus_r.rvalid;

    // Status and config take writes silently; addresses other than these and control are refused
    always_comb begin
        wr_ctrl  = bus_r.aw_addr[11:2] == 10'(`CTRL_OFFSET >> 2);
        wr_known = wr_ctrl ||
                   bus_r.aw_addr[11:2] == 10'(`STATUS_OFFSET >> 2) ||
                   bus_r.aw_addr[11:2] == 10'(`CONFIG_OFFSET >> 2);
    end

    always_comb begin
        bus_nxt = bus_r;
        if (axil_req.awvalid && !bus_r.aw_held) begin
            bus_nxt.aw_held = 1'b1;
            bus_nxt.aw_addr = axil_req.awaddr;
        end
        if (axil_req.wvalid && !bus_r.w_held) begin
            bus_nxt.w_held = 1'b1;
            bus_nxt.w_data = axil_req.wdata;
            bus_nxt.w_strb = axil_req.wstrb;
        end
        if (bus_r.bvalid && axil_req.bready) begin
            bus_nxt.bvalid = 1'b0;
        end
        if (wr_go) begin
            bus_nxt.aw_held = 1'b0;
            bus_nxt.w_held  = 1'b0;
            bus_nxt.bvalid  = 1'b1;
            bus_nxt.bresp   = `RESP_OKAY;
            if (wr_ctrl) begin
                if (bus_r.w_strb[0]) begin
                    bus_nxt.enable = bus_r.w_data[`CTRL_ENABLE_BIT]; // R13
                end
                if (bus_r.w_strb[1]) begin
                    bus_nxt.bank = bus_r.w_data[`CTRL_BANK_MSB:
                                                `CTRL_BANK_LSB]; // R9
                end
            end else if (!wr_known) begin
                bus_nxt.bresp = `RESP_SLVERR;
            end
        end
        if (bus_r.rvalid && axil_req.rready) begin
            bus_nxt.rvalid = 1'b0;
        end
        if (rd_go) begin
            bus_nxt.rvalid = 1'b1;
            bus_nxt.rresp  = `RESP_OKAY;
            case (axil_req.araddr[11:2])
                10'(`CTRL_OFFSET >> 2):   bus_nxt.rdata = ctrl_word;
                10'(`STATUS_OFFSET >> 2): bus_nxt.rdata = stat_word;
                10'(`CONFIG_OFFSET >> 2): bus_nxt.rdata = cfg_word;
                default: begin
                    bus_nxt.rdata = 32'h0000_0000;
                    bus_nxt.rresp = `RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bus_r        <= '0;
            bus_r.enable <= 1'(`CTRL_RESET);
            bus_r.bank   <= `BANK_RESET;
        end else begin
            bus_r <= bus_nxt;
        end
    end

    always_comb begin
        axil_rsp         = '0;
        axil_rsp.awready = !bus_r.aw_held;
        axil_rsp.wready  = !bus_r.w_held;
        axil_rsp.bvalid  = bus_r.bvalid;
        axil_rsp.bresp   = bus_r.bresp;
        axil_rsp.arready = !bus_r.rvalid;
        axil_rsp.rvalid  = bus_r.rvalid;
        axil_rsp.rdata   = bus_r.rdata;
        axil_rsp.rresp   = bus_r.rresp;
    end

    ////////////////////////////////////////////////////////////////////////
    // Settings into the capture domain
    // Enable and bank are quasi-static; three stages, a change is taken
    // only when the last two agree so a half-moved bank never reaches pins

    typedef struct packed {
        // Synchroniser stages
        trace_sel_type s1;
        trace_sel_type s2;
        trace_sel_type s3;
        // Selection last seen steady
        trace_sel_type held;
    } link_state_type;

    link_state_type link_r;
    link_state_type link_nxt;
    trace_sel_type  sel_src;

    assign sel_src = '{enable: eff_enable, bank: eff_bank};

    always_comb begin
        link_nxt    = link_r;
        link_nxt.s1 = sel_src;
        link_nxt.s2 = link_r.s1;
        link_nxt.s3 = link_r.s2;
        if (link_r.s2 == link_r.s3) begin
            link_nxt.held = link_r.s3;
        end
    end

    always_ff @(posedge capture_clk) begin
        if (!capture_resetn) begin
            link_r <= '0;
        end else begin
            link_r <= link_nxt;
        end
    end

    // Always-on is a build constant, so it needs no crossing at all
    trace_sel_type sel_now;
    assign sel_now = ALWAYS_ON
                   ? trace_sel_type'{enable: 1'b1, bank: `BANK_RESET}
                   : link_r.held;                              // R4 R5

    ////////////////////////////////////////////////////////////////////////
    // Bank multiplexer

    // A bank number past the last bank gives zeros rather than wrapping
    logic [BANK_WIDTH-1:0] bank_pick;

    always_comb begin
        bank_pick = '0;
        if (32'(sel_now.bank) < BANK_COUNT) begin
            bank_pick = bank_data[sel_now.bank];                 // R9 R11
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output path

    generate
        if (SYNC_MODE) begin : g_sync
            // Deeper pipes for the faster ranges; longer latency is the price
            localparam int STAGES = (FREQ_RANGE == FREQ_0_100) ? 1 :
                                    (FREQ_RANGE == FREQ_301_500)
                                        ? PIPE_STAGES + 1 : PIPE_STAGES; // R7

            // Data and enable travel together so the pins never show a
            // word under the wrong enable
            typedef struct packed {
                logic [STAGES-1:0][BANK_WIDTH-1:0] data;
                logic [STAGES-1:0]                 en;
            } pipe_state_type;

            pipe_state_type        pipe_r;
            pipe_state_type        pipe_nxt;
            logic [BANK_WIDTH-1:0] pipe_out;

            always_comb begin
                pipe_nxt         = pipe_r;
                pipe_nxt.data[0] = bank_pick;                    // R1
                pipe_nxt.en[0]   = sel_now.enable;
                for (int i = 1; i < STAGES; i++) begin
                    pipe_nxt.data[i] = pipe_r.data[i-1];         // R1
                    pipe_nxt.en[i]   = pipe_r.en[i-1];
                end
            end

            always_ff @(posedge capture_clk) begin
                if (!capture_resetn) begin
                    pipe_r <= '0;
                end else begin
                    pipe_r <= pipe_nxt;
                end
            end

            assign pipe_out = pipe_r.data[STAGES-1];

            // Two halves per input clock: low half while the clock is high,
            // high half while it is low, so the analyzer uses both edges
            if (TDM_RATE == 2) begin : g_ddr
                assign trace_data_pins = capture_clk
                    ? pipe_out[PIN_COUNT-1:0]
                    : pipe_out[2*PIN_COUNT-1:PIN_COUNT];         // R10
            end else begin : g_sdr
                assign trace_data_pins = pipe_out[PIN_COUNT-1:0]; // R1
            end
            assign trace_clock_pin    = capture_clk;             // R1
            assign trace_data_pins_oe = pipe_r.en[STAGES-1];     // R13
            assign trace_clock_pin_oe = pipe_r.en[STAGES-1];
        end else begin : g_async
            // No flop on the data path; pins follow the bank directly
            // No latency, but also no retiming: skew between bits remains
            assign trace_data_pins    = bank_pick[PIN_COUNT-1:0]; // R2
            assign trace_clock_pin    = bank_pick[PIN_COUNT];     // R3
            assign trace_data_pins_oe = sel_now.enable;           // R4 R13
            assign trace_clock_pin_oe = sel_now.enable;
        end
    endgenerate

endmodule : trace_output_port

//--- hdl/trace_port_consts.svh
// Constants of the trace output port: offsets, fields, resets, bus answers
`ifndef TRACE_PORT_CONSTS_SVH
`define TRACE_PORT_CONSTS_SVH

// Register byte offsets
`define CTRL_OFFSET      12'h000
`define STATUS_OFFSET    12'h004
`define CONFIG_OFFSET    12'h008

// Control register fields
`define CTRL_ENABLE_BIT  0
`define CTRL_BANK_LSB    8
`define CTRL_BANK_MSB    13

// Status register fields
`define STAT_ENABLE_BIT  0
`define STAT_BANK_LSB    8
`define STAT_BANK_MSB    13

// Config register fields (read only, build options)
`define CFG_SYNC_BIT     0
`define CFG_ALWAYS_BIT   1
`define CFG_AUTO_BIT     2
`define CFG_TDM2_BIT     3
`define CFG_FREQ_LSB     4
`define CFG_FREQ_MSB     5
`define CFG_PINS_LSB     8
`define CFG_PINS_MSB     15
`define CFG_BANKS_LSB    16
`define CFG_BANKS_MSB    22

// Reset values
`define CTRL_RESET       32'h0000_0000
`define BANK_RESET       6'h00

// Bus answers
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

//--- hdl/trace_port_pkg.sv
// Types of the trace output port
package trace_port_pkg;

    typedef enum {
        FREQ_0_100,
        FREQ_101_250,
        FREQ_251_300,
        FREQ_301_500
    } freq_range_type;

    typedef struct packed {
        logic        awvalid;
        logic [11:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [11:0] araddr;
        logic        rready;
    } axil_req_type;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axil_rsp_type;

    // Settings handed from the bus domain to the link domain
    typedef struct packed {
        logic       enable;
        logic [5:0] bank;
    } trace_sel_type;

endpackage : trace_port_pkg

//--- dv/trace_output_port_checker.sv
// Concurrent checks on the trace output port's ports
`timescale 1ns/1ps
`include "trace_port_consts.svh"
module trace_output_port_checker
    import trace_port_pkg::*;
#(
    parameter int  PIN_COUNT  = 8,
    parameter int  BANK_COUNT = 4,
    parameter bit  SYNC_MODE  = 1'b1,
    parameter int  TDM_RATE   = 1,
    parameter bit  ALWAYS_ON  = 1'b0,
    localparam int BW = (SYNC_MODE ? PIN_COUNT : PIN_COUNT + 1) * TDM_RATE
) (
    // Bus side
    input wire logic                          aclk,
    input wire logic                          aresetn,
    input wire axil_req_type                  axil_req,
    input wire axil_rsp_type                  axil_rsp,
    // Capture side and pins
    input wire logic                          capture_clk,
    input wire logic [BANK_COUNT-1:0][BW-1:0] bank_data,
    input wire logic                          trace_clock_pin,
    input wire logic                          trace_clock_pin_oe,
    input wire logic [PIN_COUNT-1:0]          trace_data_pins,
    input wire logic                          trace_data_pins_oe
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_taken;
        axil_req.awvalid && axil_rsp.awready
            && axil_req.wvalid && axil_rsp.wready;
    endsequence
    sequence rd_taken;
        axil_req.arvalid && axil_rsp.arready;
    endsequence
    // Only bank 0 is known here, so timing mode is judged in always-on
    wire timing_on = !SYNC_MODE && ALWAYS_ON;
    write_answer_a: assert property (wr_taken |-> ##2 axil_rsp.bvalid)
        else $error("write response late");
    read_answer_a: assert property (rd_taken |=> axil_rsp.rvalid)
        else $error("read response late");
    hole_read_a: assert property ((rd_taken
        and ((axil_req.araddr >> 2) > (`CONFIG_OFFSET >> 2)))
        |=> axil_rsp.rresp == `RESP_SLVERR && axil_rsp.rdata == 32'h0)
        else $error("unmapped read not refused");
    resp_drop_a: assert property (axil_rsp.bvalid && axil_req.bready
        |=> !axil_rsp.bvalid) else $error("write response stuck");
    read_block_a: assert property (axil_rsp.rvalid |-> !axil_rsp.arready)
        else $error("read taken while answer pending");
    sync_edge_a: assert property (SYNC_MODE && TDM_RATE == 1
        && $changed(trace_data_pins) |-> $rose(capture_clk))
        else $error("trace pins moved off clock");
    timing_data_a: assert property (timing_on
        |-> trace_data_pins == bank_data[0][PIN_COUNT-1:0])
        else $error("timing data not bank 0");
    timing_clk_a: assert property (timing_on
        |-> trace_clock_pin == bank_data[0][BW-1])
        else $error("clock pin not extra data bit");
    always_oe_a: assert property (ALWAYS_ON
        |-> trace_data_pins_oe && trace_clock_pin_oe)
        else $error("drivers off in always-on build");
    oe_pair_a: assert property (trace_data_pins_oe == trace_clock_pin_oe)
        else $error("pin enables disagree");
endmodule : trace_output_port_checker

bind trace_output_port trace_output_port_checker #(
    .PIN_COUNT(PIN_COUNT), .BANK_COUNT(BANK_COUNT), .SYNC_MODE(SYNC_MODE),
    .TDM_RATE(TDM_RATE), .ALWAYS_ON(ALWAYS_ON)
) chk_u (.aclk, .aresetn, .axil_req, .axil_rsp, .capture_clk, .bank_data,
    .trace_clock_pin, .trace_clock_pin_oe, .trace_data_pins,
    .trace_data_pins_oe);

//--- dv/trace_analyzer_model.sv
// Logic analyzer model capturing the trace pins at the probe
`timescale 1ns/1ps
module trace_analyzer_model #(
    parameter int PIN_COUNT = 8
) (
    // Probe connector
    input  wire logic                 trace_clock_pin,
    input  wire logic [PIN_COUNT-1:0] trace_data_pins,
    input  wire logic                 trace_data_pins_oe,
    // Captured sample
    output logic [PIN_COUNT-1:0]      word_r,
    output logic                      live_r
);
    // Falling edge: mid-word phase, away from where the pins change
    always @(negedge trace_clock_pin) begin
        // An undriven probe reads as noise; shown here as the inverse
        word_r <= trace_data_pins_oe ? trace_data_pins : ~trace_data_pins;
        live_r <= trace_data_pins_oe;
    end
endmodule : trace_analyzer_model

//--- dv/trace_output_port_bench.sv
// Bench of the trace output port: bus, pipeline and timing mode
`timescale 1ns/1ps
`include "trace_port_consts.svh"
module trace_output_port_bench;
    import trace_port_pkg::*;
    // Pipeline depth of the top frequency range with two stages
    localparam int STAGES = 3;
    logic            aclk = 1'b0;
    logic            aresetn = 1'b0;
    logic            capture_clk = 1'b0;
    logic            capture_resetn = 1'b0;
    axil_req_type    req [2];
    axil_rsp_type    rsp [2];
    logic [3:0][7:0] bank_s = '0;
    logic [3:0][8:0] bank_a = '0;
    logic [7:0]      cnt = 8'h00;
    logic [7:0]      tdp_s, tdp_a, word;
    logic            tck_s, tck_a, oe_s, oe_a, cko_s, cko_a, live;
    logic [1:0]      resp;
    logic [31:0]     rdv;
    int              bad_count = 0;
    int              checks_done = 0;
    int              cycles = 0;

    trace_output_port dut_u (.aclk, .aresetn, .axil_req(req[0]),
        .axil_rsp(rsp[0]), .capture_clk, .capture_resetn, .bank_data(bank_s),
        .trace_clock_pin(tck_s), .trace_clock_pin_oe(cko_s),
        .trace_data_pins(tdp_s), .trace_data_pins_oe(oe_s));
    trace_output_port #(.SYNC_MODE(1'b0), .ALWAYS_ON(1'b1)) dut_timing_u (
        .aclk, .aresetn, .axil_req(req[1]), .axil_rsp(rsp[1]), .capture_clk,
        .capture_resetn, .bank_data(bank_a), .trace_clock_pin(tck_a),
        .trace_clock_pin_oe(cko_a), .trace_data_pins(tdp_a),
        .trace_data_pins_oe(oe_a));
    trace_analyzer_model model_u (.trace_clock_pin(tck_s),
        .trace_data_pins(tdp_s), .trace_data_pins_oe(oe_s), .word_r(word),
        .live_r(live));

    always #5 aclk = ~aclk;
    always #32 capture_clk = ~capture_clk;
    // Banks move every rising edge, so pipeline latency shows as an offset
    always @(posedge capture_clk) begin
        cnt <= cnt + 8'h01;
        for (int b = 0; b < 4; b++) begin
            bank_s[b] <= cnt + 8'h01 + 8'(b * 64);
        end
        bank_a[0] <= {cnt[1], ~cnt};
        bank_a[1] <= {cnt[0], cnt};
    end
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            results();
        end
    end

    task automatic chk(input string n, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk

    task automatic write_reg(input int i, input logic [11:0] a,
                             input logic [31:0] d);
        @(posedge aclk);
        req[i].awaddr <= a;
        req[i].wdata <= d;
        req[i].wstrb <= 4'hF;
        req[i].awvalid <= 1'b1;
        req[i].wvalid <= 1'b1;
        req[i].bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (rsp[i].awready) req[i].awvalid <= 1'b0;
            if (rsp[i].wready) req[i].wvalid <= 1'b0;
        end while (rsp[i].bvalid !== 1'b1);
        resp = rsp[i].bresp;
        req[i].bready <= 1'b0;
    endtask : write_reg

    task automatic read_reg(input int i, input logic [11:0] a);
        @(posedge aclk);
        req[i].araddr <= a;
        req[i].arvalid <= 1'b1;
        req[i].rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (rsp[i].arready) req[i].arvalid <= 1'b0;
        end while (rsp[i].rvalid !== 1'b1);
        rdv = rsp[i].rdata;
        resp = rsp[i].rresp;
        req[i].rready <= 1'b0;
    endtask : read_reg

    task automatic t_start();
        chk("sync oe idle", {cko_s, oe_s}, 0);
        read_reg(0, `CTRL_OFFSET);
        chk("ctrl reset", rdv, `CTRL_RESET);
        read_reg(0, `CONFIG_OFFSET);
        chk("sync config", rdv, 32'h0004_0835);
        read_reg(1, `CONFIG_OFFSET);
        chk("timing config", rdv, 32'h0004_0836);
        read_reg(0, 12'h010);
        chk("hole resp", resp, `RESP_SLVERR);
        chk("hole data", rdv, 0);
        chk("timing oe", {cko_a, oe_a}, 3);
        @(negedge capture_clk);
        chk("timing pins", {tck_a, tdp_a}, bank_a[0]);
        $display("test start done");
    endtask : t_start

    task automatic t_select(input int b);
        logic [7:0] exp;
        write_reg(0, `CTRL_OFFSET, 32'h1 | (b << 8));
        chk("ctrl resp", resp, `RESP_OKAY);
        repeat (12) @(posedge capture_clk);
        read_reg(0, `STATUS_OFFSET);
        chk("status", rdv, 32'h1 | (b << 8));
        repeat (4) begin
            @(negedge tck_s);
            #1;
            exp = (b < 4) ? 8'(bank_s[b[1:0]] - STAGES) : 8'h00;
            chk("trace word", word, exp);
            chk("trace oe", live, 1);
        end
        $display("test select %0d done", b);
    endtask : t_select

    task automatic t_off();
        write_reg(0, `CTRL_OFFSET, 32'h0);
        write_reg(1, `CTRL_OFFSET, 32'h0000_0300);
        write_reg(0, `STATUS_OFFSET, 32'h1);
        chk("status write resp", resp, `RESP_OKAY);
        repeat (12) @(negedge capture_clk);
        chk("sync oe off", {cko_s, oe_s}, 0);
        read_reg(1, `STATUS_OFFSET);
        chk("timing status", rdv, 32'h1);
        @(negedge capture_clk);
        chk("timing pins", {tck_a, tdp_a}, bank_a[0]);
        $display("test off done");
    endtask : t_off

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results

    initial begin
        req[0] = '0;
        req[1] = '0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (8) @(posedge capture_clk);
        capture_resetn <= 1'b1;
        repeat (4) @(negedge capture_clk);
        t_start();
        t_select(2);
        t_select(3);
        t_select(5);
        t_off();
        results();
    end
endmodule : trace_output_port_bench
